// >>> core/lanc_mdio.sv
`timescale 1ns/10ps
module lanc_mdio
    import lanc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic [3:0] phy_addr,
    input wire logic [15:0] rd_data,
    output logic mdio_out,
    output logic mdio_oe,
    output logic [4:0] reg_addr,
    output logic rd_stb,
    output logic wr_stb,
    output logic [15:0] wr_data
);
    lanc_mdio_e st_ff, nxt_st;
    logic mdc_ff, out_ff, nxt_out, oe_ff, nxt_oe, rd_ff, nxt_rd, wr_ff, nxt_wr;
    logic [4:0] cnt_ff, nxt_cnt, addr_ff, nxt_addr;
    logic [15:0] sh_ff, nxt_sh, wd_ff, nxt_wd;
    logic rise;

    assign rise = mdc & ~mdc_ff;

    // Frame engine stepped on each rising management clock edge
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        if (rise)
        begin
            unique case (st_ff)
                MS_IDLE:
                begin
                    nxt_cnt = '0;
                    if (!mdio_in)
                        nxt_st = MS_HDR;
                end
                MS_HDR:
                begin
                    nxt_sh = {sh_ff[14:0], mdio_in};
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == MD_HDR_LAST)
                    begin
                        nxt_cnt = '0;
                        nxt_addr = {sh_ff[3:0], mdio_in};
                        nxt_st = MS_SKIP;
                        // Start bit, then own address with top bit clear
                        if (sh_ff[11] && sh_ff[8:4] == {1'b0, phy_addr})
                        begin
                            if (sh_ff[10:9] == MD_OP_RD)
                                nxt_st = MS_RTA;
                            else if (sh_ff[10:9] == MD_OP_WR)
                                nxt_st = MS_WDAT;
                        end
                    end
                end
                MS_RTA:
                begin
                    nxt_oe = 1'b1;
                    nxt_out = 1'b0;
                    nxt_sh = rd_data;
                    // Strobe after capture; clear-on-read drops a page or fault flag set in the capture cycle
                    nxt_rd = 1'b1;
                    nxt_cnt = '0;
                    nxt_st = MS_RDAT;
                end
                MS_RDAT:
                begin
                    if (cnt_ff == MD_RD_BITS)
                    begin
                        nxt_oe = 1'b0;
                        nxt_out = 1'b0;
                        nxt_st = MS_IDLE;
                    end
                    else
                    begin
                        nxt_out = sh_ff[15];
                        nxt_sh = {sh_ff[14:0], 1'b0};
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                MS_WDAT, MS_SKIP:
                begin
                    nxt_sh = {sh_ff[14:0], mdio_in};
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == MD_WR_LAST)
                    begin
                        nxt_st = MS_IDLE;
                        nxt_wr = (st_ff == MS_WDAT);
                        nxt_wd = {sh_ff[14:0], mdio_in};
                    end
                end
                default:
                    nxt_st = MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            st_ff <= MS_IDLE;
            mdc_ff <= 1'b0;
            cnt_ff <= '0;
            sh_ff <= '0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            addr_ff <= '0;
            wd_ff <= '0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            mdc_ff <= mdc;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
        end
    end

    assign mdio_out = out_ff;
    assign mdio_oe = oe_ff;
    assign reg_addr = addr_ff;
    assign rd_stb = rd_ff;
    assign wr_stb = wr_ff;
    assign wr_data = wd_ff;
endmodule // lanc_mdio

// >>> core/lanc_pkg.sv
package lanc_pkg;
    // Register indices on the management bus
    localparam logic [4:0] REG_BCTL = 5'h00;
    localparam logic [4:0] REG_BSTAT = 5'h01;
    localparam logic [4:0] REG_ADV = 5'h04;
    localparam logic [4:0] REG_LPA = 5'h05;
    localparam logic [4:0] REG_EXP = 5'h06;
    localparam logic [4:0] REG_NPTX = 5'h07;

    // Field positions
    localparam int BC_RESET = 15;
    localparam int BC_AN_EN = 12;
    localparam int BC_RESTART = 9;
    localparam int BS_AN_DONE = 5;
    localparam int BS_AN_ABLE = 3;
    localparam int BS_LINK = 2;
    localparam int AB_NP = 15;
    localparam int AB_ASYM = 11;
    localparam int AB_PAUSE = 10;
    localparam int AB_100FD = 8;
    localparam int AB_100HD = 7;
    localparam int AB_10FD = 6;
    localparam int AB_10HD = 5;
    localparam int SEL_MSB = 4;
    localparam int EX_LP_AN = 0;
    localparam int EX_PAGE_RX = 1;
    localparam int EX_PD_FAULT = 4;

    // Reset and fixed values
    localparam logic [15:0] BCTL_RST = 16'h1140;
    localparam logic [15:0] ADV_RST = 16'h01E1;
    localparam logic [15:0] NPTX_RST = 16'h2001;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [SEL_MSB:0] SEL_8023 = 5'h01;

    // Timing
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned BREAK_LINK_MS = 1200;
    localparam int unsigned BREAK_LINK_CYC_DEF = BREAK_LINK_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 26;

    // Management frame fields
    localparam logic [1:0] MD_OP_RD = 2'h2;
    localparam logic [1:0] MD_OP_WR = 2'h1;
    localparam logic [4:0] MD_HDR_LAST = 5'h0C;
    localparam logic [4:0] MD_WR_LAST = 5'h11;
    localparam logic [4:0] MD_RD_BITS = 5'h10;

    typedef enum logic [2:0] {
        MS_IDLE = 3'h0,
        MS_HDR = 3'h1,
        MS_RTA = 3'h3,
        MS_RDAT = 3'h2,
        MS_WDAT = 3'h5,
        MS_SKIP = 3'h4
    } lanc_mdio_e;

    typedef enum logic [2:0] {
        AN_BREAK = 3'h0,
        AN_ABILITY = 3'h1,
        AN_NPAGE = 3'h3,
        AN_DONE = 3'h2,
        AN_OFF = 3'h6
    } lanc_state_e;

    typedef enum logic [1:0] {
        SPD_10 = 2'h0,
        SPD_100 = 2'h1,
        SPD_1000 = 2'h2
    } lanc_speed_e;

    // Decoded link partner side
    typedef struct packed {
        logic rx_valid;
        logic [15:0] rx_word;
        logic gig_fd;
        logic gig_hd;
        logic multiport;
        logic pd_10;
        logic pd_100;
        logic link_good;
    } lanc_link_in_s;

    // Resolved operating mode
    typedef struct packed {
        logic valid;
        lanc_speed_e speed;
        logic full_dup;
        logic leader;
        logic fc_allowed;
    } lanc_result_s;
endpackage

// >>> core/lanc_timer.sv
`timescale 1ns/10ps
module lanc_timer #(
    parameter int W = 26
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic done_ff;
    logic nxt_done;

    // Down counter, one-cycle pulse on expiry
    always_comb
    begin
        nxt_count = count_ff;
        nxt_done = 1'b0;
        if (start)
            nxt_count = load;
        else if (count_ff != '0)
        begin
            nxt_count = count_ff - 1'b1;
            nxt_done = (count_ff == W'(1));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            count_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
endmodule // lanc_timer

// >>> core/lanc_top.sv
`timescale 1ns/10ps
module lanc_top
    import lanc_pkg::*;
#(
    parameter int unsigned BREAK_LINK_CYC = lanc_pkg::BREAK_LINK_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [3:0] phy_addr,
    input wire logic an_strap_dis,
    input wire logic local_gig_fd,
    input wire logic local_gig_hd,
    input wire logic local_multiport,
    input wire logic tie_leader,
    input wire lanc_pkg::lanc_link_in_s link_in,
    output logic flp_tx_en,
    output logic [15:0] flp_tx_word,
    output logic tx_halt,
    output lanc_pkg::lanc_result_s result
);
    import lanc_pkg::*;

    lanc_state_e st_ff, nxt_st;
    lanc_result_s res_ff, nxt_res;
    logic [15:0] bctl_ff, nxt_bctl, adv_ff, nxt_adv, lpa_ff, nxt_lpa, nptx_ff, nxt_nptx;
    logic lp_an_ff, nxt_lp_an, page_rx_ff, nxt_page_rx, pd_fault_ff, nxt_pd_fault;
    logic done_ff, nxt_done, pd_mode_ff, nxt_pd_mode, strap_ff, nxt_strap;
    logic flp_en_ff, nxt_flp_en, halt_ff, nxt_halt, tmr_start_ff, nxt_tmr_start;
    logic [15:0] tx_word_ff, nxt_tx_word, rd_data, wr_data;
    logic [4:0] reg_addr;
    logic rd_stb, wr_stb, tmr_done;

    // Serial management port, direct access to registers 0-31
    lanc_mdio u_mdio (
        .core_clk(core_clk),
        .resetn(resetn),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .phy_addr(phy_addr),
        .rd_data(rd_data),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe),
        .reg_addr(reg_addr),
        .rd_stb(rd_stb),
        .wr_stb(wr_stb),
        .wr_data(wr_data)
    );

    // Break-link timer
    lanc_timer #(.W(TMR_W)) u_break (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(tmr_start_ff),
        .load(BREAK_LINK_CYC[TMR_W-1:0]),
        .done(tmr_done)
    );

    // Register read mux
    always_comb
    begin
        rd_data = ZERO16;
        unique case (reg_addr)
            REG_BCTL: rd_data = bctl_ff;
            REG_BSTAT:
            begin
                rd_data[BS_AN_DONE] = done_ff;
                rd_data[BS_AN_ABLE] = 1'b1;
                rd_data[BS_LINK] = link_in.link_good;
            end
            REG_ADV: rd_data = adv_ff;
            REG_LPA: rd_data = lpa_ff;
            REG_EXP:
            begin
                rd_data[EX_LP_AN] = lp_an_ff;
                rd_data[EX_PAGE_RX] = page_rx_ff;
                rd_data[EX_PD_FAULT] = pd_fault_ff;
            end
            REG_NPTX: rd_data = nptx_ff;
            default: rd_data = ZERO16;
        endcase
    end

    // Register writes, negotiation sequence and resolution
    always_comb
    begin
        logic [15:0] com;
        logic restart, go_off, en_rise;
        com = adv_ff & lpa_ff;
        restart = 1'b0;
        go_off = 1'b0;
        en_rise = 1'b0;
        nxt_st = st_ff;
        nxt_res = res_ff;
        nxt_bctl = bctl_ff;
        nxt_adv = adv_ff;
        nxt_lpa = lpa_ff;
        nxt_nptx = nptx_ff;
        nxt_lp_an = lp_an_ff;
        nxt_page_rx = page_rx_ff;
        nxt_pd_fault = pd_fault_ff;
        nxt_done = done_ff;
        nxt_pd_mode = pd_mode_ff;
        nxt_strap = strap_ff;
        nxt_flp_en = flp_en_ff;
        nxt_halt = halt_ff;
        nxt_tmr_start = 1'b0;
        nxt_tx_word = tx_word_ff;

        // Clear-on-read of page received; a new page wins below
        if (rd_stb && reg_addr == REG_EXP)
        begin
            nxt_page_rx = 1'b0;
            nxt_pd_fault = 1'b0;
        end

        if (wr_stb)
        begin
            unique case (reg_addr)
                REG_BCTL:
                begin
                    nxt_bctl = wr_data;
                    nxt_bctl[BC_RESTART] = 1'b0;
                    nxt_bctl[BC_RESET] = 1'b0;
                    if (strap_ff)
                        nxt_bctl[BC_AN_EN] = 1'b0;
                    en_rise = nxt_bctl[BC_AN_EN] & ~bctl_ff[BC_AN_EN];
                    go_off = ~nxt_bctl[BC_AN_EN];
                    restart = en_rise | (wr_data[BC_RESTART] & nxt_bctl[BC_AN_EN]);
                    if (wr_data[BC_RESET])
                    begin
                        nxt_bctl = BCTL_RST;
                        nxt_bctl[BC_AN_EN] = ~strap_ff;
                        nxt_adv = ADV_RST;
                        nxt_nptx = NPTX_RST;
                        go_off = strap_ff;
                        restart = ~strap_ff;
                    end
                end
                REG_ADV: nxt_adv = wr_data;
                REG_NPTX: nxt_nptx = wr_data;
                default: ;
            endcase
        end

        unique case (st_ff)
            AN_BREAK:
            begin
                // Silence until the break-link timer runs out
                nxt_halt = 1'b1;
                nxt_flp_en = 1'b0;
                if (tmr_done)
                begin
                    nxt_st = AN_ABILITY;
                    nxt_halt = 1'b0;
                    nxt_flp_en = 1'b1;
                    nxt_tx_word = adv_ff;
                end
            end
            AN_ABILITY:
            begin
                nxt_flp_en = 1'b1;
                nxt_tx_word = adv_ff;
                if (link_in.rx_valid)
                begin
                    nxt_lpa = link_in.rx_word;
                    nxt_lp_an = 1'b1;
                    nxt_page_rx = 1'b1;
                    nxt_pd_mode = 1'b0;
                    if (adv_ff[AB_NP] && link_in.rx_word[AB_NP])
                    begin
                        nxt_st = AN_NPAGE;
                        nxt_tx_word = nptx_ff;
                    end
                    else
                        nxt_st = AN_DONE;
                end
                else if (link_in.pd_10 && link_in.pd_100)
                    nxt_pd_fault = 1'b1;
                else if (link_in.pd_10 || link_in.pd_100)
                begin
                    // Partner sends link signals but no bursts
                    nxt_lpa = ZERO16;
                    nxt_lpa[AB_100HD] = link_in.pd_100;
                    nxt_lpa[AB_10HD] = link_in.pd_10;
                    nxt_lpa[SEL_MSB:0] = SEL_8023;
                    nxt_lp_an = 1'b0;
                    nxt_pd_mode = 1'b1;
                    nxt_st = AN_DONE;
                end
            end
            AN_NPAGE:
            begin
                nxt_tx_word = nptx_ff;
                if (link_in.rx_valid)
                begin
                    nxt_page_rx = 1'b1;
                    if (!nptx_ff[AB_NP] && !link_in.rx_word[AB_NP])
                        nxt_st = AN_DONE;
                end
            end
            AN_DONE:
            begin
                nxt_flp_en = 1'b0;
                if (!link_in.link_good && done_ff)
                begin
                    nxt_st = AN_ABILITY;
                    nxt_done = 1'b0;
                    nxt_res.valid = 1'b0;
                    nxt_flp_en = 1'b1;
                    if (pd_mode_ff)
                        nxt_pd_fault = 1'b1;
                end
                else if (!done_ff)
                begin
                    nxt_done = 1'b1;
                    // Priority: 1000FD, 1000HD, 100FD, 100HD, 10FD, 10HD
                    nxt_res.valid = 1'b1;
                    nxt_res.leader = 1'b0;
                    nxt_res.full_dup = 1'b0;
                    nxt_res.speed = SPD_10;
                    if (pd_mode_ff)
                        nxt_res.speed = lpa_ff[AB_100HD] ? SPD_100 : SPD_10;
                    else if (local_gig_fd && link_in.gig_fd)
                    begin
                        nxt_res.speed = SPD_1000;
                        nxt_res.full_dup = 1'b1;
                    end
                    else if (local_gig_hd && link_in.gig_hd)
                        nxt_res.speed = SPD_1000;
                    else if (com[AB_100FD])
                    begin
                        nxt_res.speed = SPD_100;
                        nxt_res.full_dup = 1'b1;
                    end
                    else if (com[AB_100HD])
                        nxt_res.speed = SPD_100;
                    else if (com[AB_10FD])
                        nxt_res.full_dup = 1'b1;
                    // Leader only at 1000; multiport beats single node
                    if (nxt_res.speed == SPD_1000 && !pd_mode_ff)
                    begin
                        if (local_multiport != link_in.multiport)
                            nxt_res.leader = local_multiport;
                        else
                            nxt_res.leader = tie_leader;
                    end
                    // Pause bits only reported; MAC picks the mode
                    nxt_res.fc_allowed = nxt_res.full_dup;
                end
            end
            AN_OFF:
            begin
                nxt_flp_en = 1'b0;
                nxt_halt = 1'b0;
            end
            default: nxt_st = AN_OFF;
        endcase

        if (go_off)
        begin
            nxt_st = AN_OFF;
            nxt_flp_en = 1'b0;
            nxt_halt = 1'b0;
            nxt_done = 1'b0;
            nxt_res.valid = 1'b0;
        end
        else if (restart)
        begin
            nxt_st = AN_BREAK;
            nxt_tmr_start = 1'b1;
            nxt_halt = 1'b1;
            nxt_flp_en = 1'b0;
            nxt_done = 1'b0;
            nxt_lp_an = 1'b0;
            nxt_res.valid = 1'b0;
        end
    end

    // State registers; strap caught while reset is held
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            st_ff <= AN_BREAK;
            res_ff <= '0;
            bctl_ff <= BCTL_RST;
            adv_ff <= ADV_RST;
            lpa_ff <= ZERO16;
            nptx_ff <= NPTX_RST;
            lp_an_ff <= 1'b0;
            page_rx_ff <= 1'b0;
            pd_fault_ff <= 1'b0;
            done_ff <= 1'b0;
            pd_mode_ff <= 1'b0;
            strap_ff <= an_strap_dis;
            flp_en_ff <= 1'b0;
            halt_ff <= 1'b1;
            tmr_start_ff <= 1'b1;
            tx_word_ff <= ZERO16;
        end
        else
        begin
            st_ff <= (strap_ff && st_ff == AN_BREAK && !bctl_ff[BC_AN_EN]) ? AN_OFF : nxt_st;
            res_ff <= nxt_res;
            bctl_ff <= strap_ff ? (nxt_bctl & ~(16'h0001 << BC_AN_EN)) : nxt_bctl;
            adv_ff <= nxt_adv;
            lpa_ff <= nxt_lpa;
            nptx_ff <= nxt_nptx;
            lp_an_ff <= nxt_lp_an;
            page_rx_ff <= nxt_page_rx;
            pd_fault_ff <= nxt_pd_fault;
            done_ff <= nxt_done;
            pd_mode_ff <= nxt_pd_mode;
            strap_ff <= nxt_strap;
            flp_en_ff <= nxt_flp_en;
            halt_ff <= nxt_halt;
            tmr_start_ff <= nxt_tmr_start;
            tx_word_ff <= nxt_tx_word;
        end
    end

    assign flp_tx_en = flp_en_ff;
    assign flp_tx_word = tx_word_ff;
    assign tx_halt = halt_ff;
    assign result = res_ff;
endmodule // lanc_top

// >>> verification/lanc_partner.sv
`timescale 1ns/10ps
module lanc_partner
    import lanc_pkg::*;
(
    input wire logic core_clk,
    input wire logic flp_tx_en,
    input wire logic neg,
    input wire logic [1:0] pd,
    input wire logic [2:0] gig,
    input wire logic [15:0] page,
    output lanc_pkg::lanc_link_in_s link_in
);
    logic [3:0] cnt_ff;
    // Burst age, one page per 16 cycles of bursts
    always_ff @(posedge core_clk)
    begin
        cnt_ff <= flp_tx_en ? cnt_ff + 4'h1 : 4'h0;
    end
    // Page only while bursts run, word scrambled otherwise
    always_comb
    begin
        link_in.rx_valid = neg && flp_tx_en && cnt_ff == 4'hF;
        link_in.rx_word = link_in.rx_valid ? page : ~page ^ {12'h000, cnt_ff};
        {link_in.gig_fd, link_in.gig_hd, link_in.multiport} = gig;
        {link_in.pd_100, link_in.pd_10} = pd;
        link_in.link_good = neg || (pd != 2'h0);
    end
endmodule // lanc_partner

// >>> verification/lanc_properties.sv
`timescale 1ns/10ps
module lanc_props
    import lanc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire lanc_pkg::lanc_link_in_s link_in,
    input wire logic flp_tx_en,
    input wire logic tx_halt,
    input wire lanc_pkg::lanc_result_s result
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Lone 100 link while pulsing, then a 100 half result
    sequence s_pd;
        flp_tx_en && link_in.pd_100 && !link_in.pd_10 && link_in.link_good && !link_in.rx_valid;
    endsequence
    sequence s_pd100;
        result.valid && result.speed == SPD_100 && !result.full_dup;
    endsequence
    pd_mode_a: assert property (s_pd |-> ##[1:3] s_pd100)
        else $error("parallel detect did not settle at 100");
    // Break link keeps pulses off for its whole length
    halt_quiet_a: assert property (tx_halt |-> !flp_tx_en)
        else $error("pulses sent during break link");
    halt_drop_a: assert property ($rose(tx_halt) |-> !result.valid)
        else $error("result kept across restart");
    halt_len_a: assert property ($rose(tx_halt) |-> tx_halt[*8])
        else $error("break link ended early");
    // Lost link goes back to sending abilities
    loss_resume_a: assert property (result.valid && !link_in.link_good
        |-> ##[1:3] (!result.valid && flp_tx_en))
        else $error("no resume after link loss");
    // Role only at gigabit, flow control only at full duplex
    leader_gig_a: assert property (result.valid && result.speed != SPD_1000 |-> !result.leader)
        else $error("leader set below gigabit");
    fc_dup_a: assert property (result.valid |-> result.fc_allowed == result.full_dup)
        else $error("flow control not tied to duplex");
    // Read turnaround drives zero and holds the bus
    ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe[*8])
        else $error("turnaround not driven low");
endmodule // lanc_props

bind lanc_top lanc_props chk (.core_clk(core_clk), .resetn(resetn), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .link_in(link_in), .flp_tx_en(flp_tx_en), .tx_halt(tx_halt),
    .result(result));

// >>> verification/tb_link_autoneg_control.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_link_autoneg_control;
    import lanc_pkg::*;
    localparam int BLC = 20;
    logic core_clk = 0, resetn = 0, mdc = 0, sta_d = 1, strap = 0, neg = 0;
    logic [1:0] pd = 2'h0;
    logic [2:0] gig = 3'h0, e;
    logic [3:0] lgig = 4'h0;
    logic [15:0] page = 16'h0000, adv, rd, ftw;
    logic ld, mdio_out, mdio_oe, flp_tx_en, tx_halt;
    int num_errors = 0, n_compared = 0, seed = 34, hc = 0, hlen = 0, hl;
    wire logic mdio_in;
    lanc_link_in_s link_in;
    lanc_result_s result;
    // Station drive sta_d shows through when the block releases the line
    assign mdio_in = mdio_oe ? mdio_out : sta_d;
    always #10 core_clk = ~core_clk;
    // Length of the last halt run
    always @(posedge core_clk)
    begin
        hc <= tx_halt ? hc + 1 : 0;
        if (!tx_halt && hc != 0) hlen <= hc;
    end
    lanc_top #(.BREAK_LINK_CYC(BLC)) uut (.core_clk(core_clk), .resetn(resetn), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(4'h5),
        .an_strap_dis(strap), .local_gig_fd(lgig[3]), .local_gig_hd(lgig[2]),
        .local_multiport(lgig[1]), .tie_leader(lgig[0]), .link_in(link_in),
        .flp_tx_en(flp_tx_en), .flp_tx_word(ftw), .tx_halt(tx_halt), .result(result));
    lanc_partner peer (.core_clk(core_clk), .flp_tx_en(flp_tx_en), .neg(neg), .pd(pd),
        .gig(gig), .page(page), .link_in(link_in));
    task automatic print_verdict;
    begin
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // One management frame, mdc at an eighth of the core clock
    task automatic mdio(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
        logic [33:0] v;
    begin
        v = {4'hD, op, 5'h05, ra, (op == MD_OP_RD) ? 2'h3 : 2'h2, wd};
        for (int i = 33; i >= 0; i--)
        begin
            sta_d = v[i];
            repeat (4) @(negedge core_clk);
            rd = {rd[14:0], mdio_in};
            mdc = 1;
            repeat (4) @(negedge core_clk);
            mdc = 0;
        end
    end
    endtask
    task automatic rdchk(input logic [4:0] ra, input logic [15:0] m, input logic [15:0] x);
    begin
        mdio(MD_OP_RD, ra, 16'hFFFF);
        `CHK("reg", x, rd & m)
    end
    endtask
    task automatic wait_valid(input logic want);
    begin
        hl = 0;
        while (result.valid !== want && hl < 4000)
        begin
            @(negedge core_clk);
            hl++;
        end
        if (hl >= 4000)
        begin
            num_errors++;
            print_verdict;
        end
    end
    endtask
    // Best common mode as {speed, full duplex}
    function automatic logic [2:0] best(input logic [15:0] a, input logic [15:0] p);
        logic [5:0] c;
    begin
        c = {lgig[3] & gig[2], lgig[2] & gig[1], a[8:5] & p[8:5]};
        best = c[5] ? 3'h5 : c[4] ? 3'h4 : c[3] ? 3'h3 : c[2] ? 3'h2 : c[1] ? 3'h1 : 3'h0;
    end
    endfunction
    initial
    begin
        repeat (6) @(negedge core_clk);
        resetn = 1;
        repeat (2) @(negedge core_clk);
        rdchk(REG_BCTL, 16'hFFFF, BCTL_RST);
        rdchk(REG_NPTX, 16'hFFFF, NPTX_RST);
        rdchk(5'h02, 16'hFFFF, ZERO16);
        for (int k = 0; k < 6; k++)
        begin
            adv = (16'($random(seed)) & 16'h0DE0) | 16'h0021;
            page = (16'($random(seed)) & 16'h0DE0) | 16'h0021;
            lgig = 4'($random(seed));
            gig = 3'($random(seed));
            neg = 1;
            mdio(MD_OP_WR, REG_ADV, adv);
            mdio(MD_OP_WR, REG_BCTL, 16'h1340);
            wait_valid(1);
            e = best(adv, page);
            ld = e[2:1] == 2'h2 && (lgig[1] != gig[0] ? lgig[1] : lgig[0]);
            `CHK("res", {1'b1, e, ld, e[0]}, result)
            `CHK("halt", 1'b1, hlen >= BLC)
            `CHK("txw", adv, ftw)
            rdchk(REG_LPA, 16'hFFFF, page);
            rdchk(REG_EXP, 16'h0001, 16'h0001);
        end
        neg = 0;
        wait_valid(0);
        `CHK("flp", 1'b1, flp_tx_en)
        for (int k = 1; k < 3; k++)
        begin
            pd = 2'(k);
            wait_valid(1);
            rdchk(REG_LPA, 16'hFFFF, k == 2 ? 16'h0081 : 16'h0021);
            rdchk(REG_EXP, 16'h0001, 16'h0000);
            pd = 2'h0;
            wait_valid(0);
        end
        pd = 2'h3;
        repeat (20) @(negedge core_clk);
        rdchk(REG_EXP, 16'h0010, 16'h0010);
        mdio(MD_OP_WR, REG_BCTL, 16'h0140);
        `CHK("off", 2'h0, {flp_tx_en, tx_halt})
        pd = 2'h0;
        neg = 1;
        mdio(MD_OP_WR, REG_BCTL, 16'h1140);
        wait_valid(1);
        `CHK("halt", 1'b1, hlen >= BLC)
        resetn = 0;
        strap = 1;
        repeat (6) @(negedge core_clk);
        resetn = 1;
        repeat (2) @(negedge core_clk);
        mdio(MD_OP_WR, REG_BCTL, 16'h1340);
        rdchk(REG_BCTL, 16'h1000, 16'h0000);
        `CHK("flp", 1'b0, flp_tx_en)
        print_verdict;
    end
endmodule // tb_link_autoneg_control
